// file: sfp_pin_if.sv
// Pin front end: select, standby, pause, reset, multi-lane shifting, status guard
// Function
// - Deselected: all outputs high impedance
// - Deselected: ignore all serial input
// - Select low exits standby, accepts transfers
// - First instruction needs select falling edge
// - Single mode: sample input on rising edge
// - Single mode: drive output on falling edge
// - Dual/quad: lanes bidirectional, write rise, read fall
// - Lock and guard low reject protected writes
// - Lock clear: status writes always allowed
// - Quad enable disables write protect function
// - Shared pin: pause, reset, or data three
// - Pause suspends without losing partial command
// - Paused and selected: serial output floats
// - Hardware reset low: held reset, outputs float
// - Master avoids reset during internal writes
// - Dedicated variant: shared pin is pause unless quad enabled
// - Function bit zero disables dedicated reset
// - Both clock polarities, rise in, fall out
`timescale 1ns/1ps
module sfp_pin_if
  import sfp_pkg::*;
#(
  parameter bit DEDICATED_RESET = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic chip_sel_b,
  input wire logic dedicated_reset_b,
  input wire logic [3:0] data_line_in,
  output logic [3:0] data_line_out,
  output logic [3:0] data_line_oe_b,
  input wire sfp_pkg::sfp_mode_t lane_mode,
  input wire logic tx_enable,
  input wire logic [7:0] tx_byte,
  output logic tx_taken,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic selected,
  output logic standby,
  output logic paused,
  output logic hw_reset_active,
  input wire logic busy_internal,
  output logic busy_reset_hit,
  input wire logic status_wr,
  input wire logic [7:0] status_wr_data,
  output logic [7:0] status_reg,
  output logic status_wr_rejected,
  input wire logic pin_role_wr,
  input wire logic pin_role_wr_data,
  output logic pin_role_select_bit,
  input wire logic func_wr,
  input wire logic func_rst_dis_data,
  output logic dedicated_reset_disable
);
  import sfp_pkg::*;

  logic [7:0] sync_q;
  logic sclk_s, cs_b_s, drst_b_s;
  logic [3:0] dl_s;
  // Select and pause pins idle high so a false edge is not seen at start
  sfp_sync #(.WIDTH(8)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in({serial_clk, chip_sel_b, dedicated_reset_b, 1'b0, data_line_in}),
    .reset_val(8'hEF),
    .sync_out(sync_q)
  );
  assign sclk_s = sync_q[7];
  assign cs_b_s = sync_q[6];
  assign drst_b_s = sync_q[5];
  assign dl_s = sync_q[3:0];

  logic sclk_d, cs_b_d;
  logic [7:0] sr, next_sr;
  logic role, next_role, rdis, next_rdis;
  logic wr_rej, next_wr_rej;
  logic quad_en, lock, guard_low, pause_pin_b, reset_pin_b, hw_rst, pausing;
  logic rise, fall, cs_fall;

  assign quad_en = sr[SFP_SR_QE];
  assign lock = sr[SFP_SR_LOCK];
  // Guard level only counts while lane two is not data
  assign guard_low = !quad_en && !dl_s[2];
  always_comb begin
    pause_pin_b = 1'b1;
    reset_pin_b = 1'b1;
    if (!quad_en) begin
      if (DEDICATED_RESET || !role) begin
        pause_pin_b = dl_s[3];
      end else begin
        reset_pin_b = dl_s[3];
      end
    end
  end
  // Reset pin on dedicated variants, unless disabled
  assign hw_rst = !reset_pin_b || (DEDICATED_RESET && !rdis && !drst_b_s);
  assign pausing = !pause_pin_b && !cs_b_s;
  assign rise = sclk_s && !sclk_d && !pausing;
  assign fall = !sclk_s && sclk_d && !pausing;
  assign cs_fall = cs_b_d && !cs_b_s;

  // Status and configuration bits
  always_comb begin
    next_sr = sr;
    next_role = role;
    next_rdis = rdis;
    next_wr_rej = 1'b0;
    if (status_wr) begin
      if (lock && guard_low) begin
        next_sr = (sr & SFP_SR_GUARD_MASK) | (status_wr_data & ~SFP_SR_GUARD_MASK);
        next_wr_rej = 1'b1;
      end else begin
        next_sr = status_wr_data;
      end
    end
    if (pin_role_wr) begin
      next_role = pin_role_wr_data;
    end
    if (func_wr && func_rst_dis_data) begin
      next_rdis = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sr <= SFP_SR_RESET;
      role <= SFP_PIN_ROLE_RESET;
      rdis <= SFP_RST_DIS_RESET;
      wr_rej <= 1'b0;
    end else begin
      sr <= next_sr;
      role <= next_role;
      rdis <= next_rdis;
      wr_rej <= next_wr_rej;
    end
  end

  // Link state and shifting
  sfp_state_t st, next_st;
  logic [7:0] rx_sh, next_rx_sh, rx_q, next_rx_q, tx_sh, next_tx_sh;
  logic [2:0] cnt, next_cnt;
  logic [1:0] tcnt, next_tcnt;
  logic rxv, next_rxv, txt, next_txt;
  logic [3:0] dout, next_dout, doe_b, next_doe_b;
  logic [2:0] step;
  logic [2:0] last;

  always_comb begin
    case (lane_mode)
      SFP_MODE_DUAL: begin
        step = 3'h2;
        last = 3'h6;
      end
      SFP_MODE_QUAD: begin
        step = 3'h4;
        last = 3'h4;
      end
      default: begin
        step = 3'h1;
        last = SFP_BIT_TOP;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_rx_sh = rx_sh;
    next_rx_q = rx_q;
    next_tx_sh = tx_sh;
    next_cnt = cnt;
    next_tcnt = tcnt;
    next_rxv = 1'b0;
    next_txt = 1'b0;
    next_dout = dout;
    next_doe_b = doe_b;
    case (st)
      SFP_ST_WAIT_EDGE: begin
        if (cs_fall) begin
          next_st = SFP_ST_ACTIVE;
        end
      end
      SFP_ST_IDLE: begin
        if (!cs_b_s) begin
          next_st = SFP_ST_ACTIVE;
        end
      end
      SFP_ST_ACTIVE: begin
        if (pausing) begin
          next_st = SFP_ST_PAUSED;
          next_doe_b = 4'hF;
        end else if (rise) begin
          case (lane_mode)
            SFP_MODE_DUAL: next_rx_sh = {rx_sh[5:0], dl_s[1:0]};
            SFP_MODE_QUAD: next_rx_sh = {rx_sh[3:0], dl_s};
            default: next_rx_sh = {rx_sh[6:0], dl_s[0]};
          endcase
          if (cnt >= last) begin
            next_cnt = SFP_BIT_ZERO;
            next_rx_q = next_rx_sh;
            next_rxv = 1'b1;
          end else begin
            next_cnt = cnt + step;
          end
        end else if (fall) begin
          if (!tx_enable) begin
            next_doe_b = 4'hF;
          end else begin
            case (lane_mode)
              SFP_MODE_DUAL: begin
                next_dout = {2'b00, tx_sh[7:6]};
                next_doe_b = 4'hC;
                next_tx_sh = {tx_sh[5:0], 2'b00};
              end
              SFP_MODE_QUAD: begin
                next_dout = tx_sh[7:4];
                next_doe_b = 4'h0;
                next_tx_sh = {tx_sh[3:0], 4'h0};
              end
              default: begin
                next_dout = {2'b00, tx_sh[7], 1'b0};
                next_doe_b = 4'hD;
                next_tx_sh = {tx_sh[6:0], 1'b0};
              end
            endcase
            if (tcnt == SFP_STEP_ZERO || (lane_mode == SFP_MODE_SINGLE && tcnt == SFP_DUAL_TOP)) begin
              next_txt = 1'b1;
            end
            next_tcnt = tcnt + 2'h1;
          end
        end
      end
      SFP_ST_PAUSED: begin
        // Shift state kept so the command resumes where it stopped
        if (!pausing) begin
          next_st = SFP_ST_ACTIVE;
        end
      end
      default: next_st = SFP_ST_WAIT_EDGE;
    endcase
    // Loading after each fall at tcnt zero (once a byte in dual, every other byte in quad); single mode also at tcnt three
    if (tx_enable && txt) begin
      next_tx_sh = tx_byte;
    end
    if (cs_b_s && st != SFP_ST_WAIT_EDGE) begin
      next_st = SFP_ST_IDLE;
      next_cnt = SFP_BIT_ZERO;
      next_tcnt = SFP_STEP_ZERO;
      next_rx_sh = SFP_BYTE_ZERO;
      next_tx_sh = tx_byte;
      next_doe_b = 4'hF;
    end
    if (hw_rst) begin
      next_st = SFP_ST_WAIT_EDGE;
      next_cnt = SFP_BIT_ZERO;
      next_tcnt = SFP_STEP_ZERO;
      next_rx_sh = SFP_BYTE_ZERO;
      next_doe_b = 4'hF;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= SFP_ST_WAIT_EDGE;
      rx_sh <= SFP_BYTE_ZERO;
      rx_q <= SFP_BYTE_ZERO;
      tx_sh <= SFP_BYTE_ZERO;
      cnt <= SFP_BIT_ZERO;
      tcnt <= SFP_STEP_ZERO;
      rxv <= 1'b0;
      txt <= 1'b0;
      dout <= 4'h0;
      doe_b <= 4'hF;
      sclk_d <= 1'b0;
      cs_b_d <= 1'b1;
    end else begin
      st <= next_st;
      rx_sh <= next_rx_sh;
      rx_q <= next_rx_q;
      tx_sh <= next_tx_sh;
      cnt <= next_cnt;
      tcnt <= next_tcnt;
      rxv <= next_rxv;
      txt <= next_txt;
      dout <= next_dout;
      doe_b <= next_doe_b;
      sclk_d <= sclk_s;
      cs_b_d <= cs_b_s;
    end
  end

  // Status flags, all registered
  logic sel_q, stby_q, pau_q, hwr_q, bhit_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
      stby_q <= 1'b1;
      pau_q <= 1'b0;
      hwr_q <= 1'b0;
      bhit_q <= 1'b0;
    end else begin
      sel_q <= (st == SFP_ST_ACTIVE) || (st == SFP_ST_PAUSED);
      stby_q <= cs_b_s;
      pau_q <= (st == SFP_ST_PAUSED);
      hwr_q <= hw_rst;
      bhit_q <= hw_rst && busy_internal;
    end
  end

  assign data_line_out = dout;
  assign data_line_oe_b = doe_b;
  assign tx_taken = txt;
  assign rx_byte = rx_q;
  assign rx_valid = rxv;
  assign selected = sel_q;
  assign standby = stby_q;
  assign paused = pau_q;
  assign hw_reset_active = hwr_q;
  assign busy_reset_hit = bhit_q;
  assign status_reg = sr;
  assign status_wr_rejected = wr_rej;
  assign pin_role_select_bit = role;
  assign dedicated_reset_disable = rdis;
endmodule

// file: sfp_pkg.sv
// Package: constants and types for the serial flash pin interface
package sfp_pkg;
  localparam int SFP_LANES = 4;
  localparam int SFP_BYTE_W = 8;
  localparam logic [2:0] SFP_BIT_TOP = 3'h7;
  localparam logic [2:0] SFP_BIT_ZERO = 3'h0;
  localparam logic [1:0] SFP_DUAL_TOP = 2'h3;
  localparam logic [1:0] SFP_STEP_ZERO = 2'h0;
  localparam logic [7:0] SFP_BYTE_ZERO = 8'h00;
  // Status register field positions
  localparam int SFP_SR_BP0 = 2;
  localparam int SFP_SR_BP3 = 5;
  localparam int SFP_SR_QE = 6;
  localparam int SFP_SR_LOCK = 7;
  localparam logic [7:0] SFP_SR_GUARD_MASK = 8'hFC;
  localparam logic [7:0] SFP_SR_RESET = 8'h00;
  localparam logic SFP_PIN_ROLE_RESET = 1'b0;
  localparam logic SFP_RST_DIS_RESET = 1'b0;
  localparam int SFP_FR_RST_DIS = 0;
  typedef enum logic [1:0] {
    SFP_MODE_SINGLE = 2'h0,
    SFP_MODE_DUAL = 2'h1,
    SFP_MODE_QUAD = 2'h3
  } sfp_mode_t;
  typedef enum logic [1:0] {
    SFP_ST_WAIT_EDGE = 2'h0,
    SFP_ST_IDLE = 2'h1,
    SFP_ST_ACTIVE = 2'h3,
    SFP_ST_PAUSED = 2'h2
  } sfp_state_t;
endpackage

// file: sfp_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module sfp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          stage1[gi] <= 1'b0;
          stage2[gi] <= 1'b0;
        end else begin
          stage1[gi] <= async_in[gi];
          stage2[gi] <= stage1[gi];
        end
      end
    end
  endgenerate
  // Reset value is applied combinationally only until the first samples land
  logic primed;
  logic primed2;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      primed <= 1'b0;
      primed2 <= 1'b0;
    end else begin
      primed <= 1'b1;
      primed2 <= primed;
    end
  end
  assign sync_out = primed2 ? stage2 : reset_val;
endmodule

// file: sfp_pin_if_asserts.sv
// Checker for the serial flash pin front end
`timescale 1ns/1ps
module sfp_pin_if_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chip_sel_b,
  input wire logic [3:0] data_line_oe_b,
  input wire logic rx_valid,
  input wire logic paused,
  input wire logic hw_reset_active,
  input wire logic status_wr,
  input wire logic [7:0] status_wr_data,
  input wire logic [7:0] status_reg,
  input wire logic status_wr_rejected,
  input wire logic dedicated_reset_disable
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Five cycles cover the select synchroniser
  desel_float_a: assert property (chip_sel_b [*5] |-> data_line_oe_b == 4'hF)
    else $error("pins driven while deselected");
  desel_quiet_a: assert property (chip_sel_b [*5] |-> !rx_valid)
    else $error("byte taken while deselected");
  pause_float_a: assert property (paused && $past(paused) |-> data_line_oe_b[1])
    else $error("output driven while paused");
  pause_quiet_a: assert property (paused && $past(paused) |-> !rx_valid)
    else $error("byte taken while paused");
  reset_float_a: assert property (hw_reset_active && $past(hw_reset_active) |-> data_line_oe_b == 4'hF)
    else $error("pins driven in reset");
  open_write_a: assert property (status_wr && !status_reg[7] |=> status_reg == $past(status_wr_data))
    else $error("open status write lost");
  guard_keep_a: assert property (status_wr_rejected |-> status_reg[7:2] == $past(status_reg[7:2]))
    else $error("guarded bits changed");
  rst_dis_sticky_a: assert property ($past(dedicated_reset_disable) |-> dedicated_reset_disable)
    else $error("reset disable cleared");
  cover property (rx_valid);
  cover property (status_wr_rejected);
  cover property (paused ##1 !paused);
endmodule
bind sfp_pin_if sfp_pin_if_asserts i_chk (.mclk, .rst_b, .chip_sel_b, .data_line_oe_b, .rx_valid, .paused,
  .hw_reset_active, .status_wr, .status_wr_data, .status_reg, .status_wr_rejected, .dedicated_reset_disable);

// file: sfp_master_model.sv
// Master-side model that frames bytes onto the link pins
`timescale 1ns/1ps
module sfp_master_model (
  output logic serial_clk,
  output logic chip_sel_b,
  output logic [3:0] drv,
  output logic [3:0] drv_en
);
  logic cpol;
  initial begin
    cpol = 1'b0;
    serial_clk = 1'b0;
    chip_sel_b = 1'b1;
    drv = 4'hC;
    drv_en = 4'hC;
  end
  // Clock stands still between frames
  task sel(input logic v);
    #7;
    serial_clk = cpol;
    chip_sel_b = v;
    drv_en = 4'hC;
    #400;
  endtask
  task pins(input logic guard, input logic hold_b);
    drv[2] = guard;
    drv[3] = hold_b;
  endtask
  // Data moves on the fall so it is steady at the rise
  task shift(input logic [7:0] d, input int n, input int w);
    logic [7:0] s;
    logic [1:0] keep;
    s = d;
    keep = drv[3:2];
    drv_en = (w == 1) ? 4'hD : 4'hF;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b0;
      for (int k = 0; k < w; k++) begin
        drv[k] = s[8-w+k];
      end
      s = s << w;
      #200;
      serial_clk = 1'b1;
      #200;
    end
    serial_clk = cpol;
    drv[3:2] = keep;
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
module tb_top;
  import sfp_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic dedicated_reset_b = 1'b1;
  logic tx_enable = 1'b0;
  logic busy_internal = 1'b0;
  logic status_wr = 1'b0;
  logic pin_role_wr = 1'b0;
  logic pin_role_wr_data = 1'b0;
  logic func_wr = 1'b0;
  logic func_rst_dis_data = 1'b0;
  logic [7:0] tx_byte = 8'hA5;
  logic [7:0] status_wr_data = 8'h00;
  sfp_mode_t lane_mode = SFP_MODE_SINGLE;
  logic serial_clk, chip_sel_b, tx_taken, rx_valid, selected, standby, paused, hw_reset_active;
  logic status_wr_rejected, busy_reset_hit, pin_role_select_bit, dedicated_reset_disable;
  logic [3:0] drv, drv_en, lines, data_line_out, data_line_oe_b;
  logic [7:0] rx_byte, status_reg, sr, b;
  logic [8:0] st [6] = '{9'h080, 9'h03F, 9'h1C4, 9'h081, 9'h000, 9'h100};
  logic [7:0] exp_q [$];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'h62F1;
  // Released lines show the inverse of their last level
  assign lines = (~data_line_oe_b & data_line_out) | (data_line_oe_b & (drv ^ ~drv_en));
  sfp_master_model i_mst (.serial_clk, .chip_sel_b, .drv, .drv_en);
  sfp_pin_if i_dut (.mclk, .rst_b, .serial_clk, .chip_sel_b, .dedicated_reset_b, .data_line_in(lines),
    .data_line_out, .data_line_oe_b, .lane_mode, .tx_enable, .tx_byte, .tx_taken, .rx_byte, .rx_valid,
    .selected, .standby, .paused, .hw_reset_active, .busy_internal, .busy_reset_hit, .status_wr,
    .status_wr_data, .status_reg, .status_wr_rejected, .pin_role_wr, .pin_role_wr_data, .pin_role_select_bit,
    .func_wr, .func_rst_dis_data, .dedicated_reset_disable);
  always #25 mclk = ~mclk;
  task finish_test;
    $display("Compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task swr(input logic [7:0] d);
    repeat (4) @(negedge mclk);
    status_wr_data = d;
    status_wr = 1'b1;
    @(negedge mclk);
    status_wr = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task send(input int w);
    b = 8'($random(seed));
    exp_q.push_back(b);
    i_mst.shift(b, 8 / w, w);
  endtask
  always @(negedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      finish_test();
    end
    // A byte nobody sent is compared against its own inverse
    if (rx_valid === 1'b1) begin
      chk(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : ~rx_byte);
    end
  end
  initial begin
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    tx_byte = 8'($random(seed));
    tx_enable = 1'b1;
    for (int m = 0; m < 2; m++) begin
      i_mst.cpol = m[0];
      i_mst.sel(1'b0);
      send(1);
      chk({6'h0, selected, standby}, 8'h02);
      chk({7'h0, data_line_oe_b[1]}, 8'h00);
      send(1);
      i_mst.sel(1'b1);
      chk({4'h0, data_line_oe_b}, 8'h0F);
    end
    @(negedge mclk);
    tx_enable = 1'b0;
    i_mst.shift(8'h5A, 8, 1);
    sr = 8'h00;
    foreach (st[i]) begin
      i_mst.pins(st[i][8], 1'b1);
      sr = (sr[7] && !sr[6] && !st[i][8]) ? {sr[7:2], st[i][1:0]} : st[i][7:0];
      swr(st[i][7:0]);
      chk(status_reg, sr);
    end
    swr(8'h40);
    for (int w = 2; w <= 4; w += 2) begin
      @(negedge mclk);
      lane_mode = (w == 2) ? SFP_MODE_DUAL : SFP_MODE_QUAD;
      i_mst.sel(1'b0);
      send(w);
      send(w);
      i_mst.sel(1'b1);
    end
    @(negedge mclk);
    lane_mode = SFP_MODE_SINGLE;
    swr(8'h00);
    i_mst.sel(1'b0);
    b = 8'($random(seed));
    exp_q.push_back(b);
    i_mst.shift(b, 4, 1);
    i_mst.pins(1'b1, 1'b0);
    #400;
    chk({6'h0, paused, data_line_oe_b[1]}, 8'h03);
    i_mst.shift(~b, 4, 1);
    i_mst.pins(1'b1, 1'b1);
    #400;
    i_mst.shift(b << 4, 4, 1);
    i_mst.sel(1'b1);
    @(negedge mclk);
    pin_role_wr_data = 1'b1;
    pin_role_wr = 1'b1;
    busy_internal = 1'b1;
    @(negedge mclk);
    pin_role_wr = 1'b0;
    i_mst.pins(1'b1, 1'b0);
    #400;
    chk({4'h0, pin_role_select_bit, hw_reset_active, busy_reset_hit, paused}, 8'h0E);
    chk({4'h0, data_line_oe_b}, 8'h0F);
    i_mst.pins(1'b1, 1'b1);
    @(negedge mclk);
    busy_internal = 1'b0;
    func_rst_dis_data = 1'b1;
    func_wr = 1'b1;
    @(negedge mclk);
    func_rst_dis_data = 1'b0;
    @(negedge mclk);
    func_wr = 1'b0;
    chk({7'h0, dedicated_reset_disable}, 8'h01);
    repeat (10) @(negedge mclk);
    chk(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule
